// ===== pkg/scs_pkg.sv
// strap sampler constants, encodings and carrier structs
package scs_pkg;

    // strap pin positions in the sampled vector
    localparam int SCS_NPIN = 12;
    localparam int SCS_PIN_START = 0;
    localparam int SCS_PIN_INBAND = 1;
    localparam int SCS_PIN_ROLE = 2;
    localparam int SCS_PIN_SPEED = 3;
    localparam int SCS_PIN_WAKE = 4;
    localparam int SCS_PIN_RXD0 = 5;
    localparam int SCS_PIN_RXD1 = 6;
    localparam int SCS_PIN_RXD2 = 7;
    localparam int SCS_PIN_RXD3 = 8;
    localparam int SCS_PIN_RXER = 9;
    localparam int SCS_PIN_RXDV = 10;
    localparam int SCS_PIN_SDO = 11;

    // start, inband off, mac role, 100M, aneg, mii, miim, normal, no filter
    localparam logic [SCS_NPIN-1:0] SCS_STRAP_DEFAULT = 12'h01f;

    // pull-up settle time after our drivers let go
    localparam int SCS_CLK_PERIOD_NS = 5;
    localparam int SCS_SETTLE_NS = 100;
    localparam int SCS_SETTLE_CYC =
        (SCS_SETTLE_NS + SCS_CLK_PERIOD_NS - 1) / SCS_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SCS_ST_SAMPLE = 2'b00,
        SCS_ST_CAPTURE = 2'b01,
        SCS_ST_RUN = 2'b11
    } scs_state_e;

    typedef enum logic [1:0] {
        SCS_P3_MII = 2'b00,
        SCS_P3_RMII = 2'b01,
        SCS_P3_RSVD = 2'b10,
        SCS_P3_RGMII = 2'b11
    } scs_port3_if_e;

    typedef enum logic [1:0] {
        SCS_MG_MIIM = 2'b00,
        SCS_MG_I2C = 2'b01,
        SCS_MG_SPI = 2'b10
    } scs_mgmt_e;

    localparam logic [1:0] SCS_PHY_RSVD = 2'b00;
    localparam logic [1:0] SCS_PHY_ANEG = 2'b01;
    localparam logic [1:0] SCS_PHY_MDIX = 2'b10;
    localparam logic [1:0] SCS_PHY_MDI = 2'b11;

    typedef struct packed {
        logic forward_en;
        logic inband_mgmt_en;
        scs_port3_if_e port3_if;
        logic mii_phy_mode;
        logic rmii_ref_out;
        logic inband_status_en;
        logic port3_gig;
        logic speed_conflict;
        scs_mgmt_e mgmt;
        logic aneg_eee;
        logic force_100fd;
        logic fixed_mdix;
        logic phy_cfg_rsvd;
        logic test_mode;
        logic emission_filter;
    } scs_cfg_s;

    typedef struct packed {
        logic [SCS_NPIN-1:0] out;
        logic [SCS_NPIN-1:0] oe;
    } scs_pin_s;

endpackage : scs_pkg

// ===== hdl/scs_strap_hold.sv
// per-bit strap holding register with load strobe
`timescale 1ns/100ps
`default_nettype none
module scs_strap_hold
    import scs_pkg::*;
#(
    parameter int W = SCS_NPIN,
    parameter logic [W-1:0] RST_VAL = SCS_STRAP_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic bit_d;
            logic bit_q;
            // only a load strobe or reset may change a held bit
            always_comb begin
                bit_d = load_i ? d_i[g] : bit_q;
            end
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    bit_q <= RST_VAL[g];
                end else begin
                    bit_q <= bit_d;
                end
            end
            assign q_o[g] = bit_q;
        end
    endgenerate

endmodule : scs_strap_hold
`default_nettype wire

// ===== hdl/scs_strap_sampler.sv
// strap sampler top: capture sequencing, pin release and config decode
// Operation
// - capture all straps at end of reset
// - recapture on power-down exit and reset release
// - start strap low blocks forwarding until start
// - inband strap low enables; never with i2c
// - role low: phy mode, refclk out, no status
// - role high: mac mode, refclk in, status
// - speed strap low gigabit, high 100M
// - rxd3/rxd2 pick mii, rmii, rgmii
// - rxd1/rxd0 pick miim, i2c or spi
// - rx_er/wake pick phy negotiation setup
// - rx_dv high is test mode; never strapped
// - sdo high enables emission filter
`timescale 1ns/100ps
`default_nettype none
module scs_strap_sampler
    import scs_pkg::*;
#(
    parameter int SETTLE_CYC = SCS_SETTLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sw_reset_i,
    input wire logic pwr_down_i,
    input wire logic sw_start_i,
    input wire logic [SCS_NPIN-1:0] strap_in_i,
    input wire scs_pin_s func_i,
    output logic [SCS_NPIN-1:0] pin_o,
    output logic [SCS_NPIN-1:0] pin_oe_o,
    output logic cfg_valid_o,
    output scs_cfg_s cfg_o
);

    localparam int CW = $clog2(SETTLE_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(SETTLE_CYC - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);

    scs_state_e state_q;
    scs_state_e state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic busy;
    logic load;
    logic [SCS_NPIN-1:0] strap_q;

    // any of these keeps the straps in their sampling window
    assign busy = sw_reset_i | pwr_down_i;
    assign load = (state_q == SCS_ST_CAPTURE);

    // sequencing: reset release, sw reset end, power-down exit
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            SCS_ST_SAMPLE: begin
                // settle restarts while any reset source is held
                if (busy) begin
                    cnt_d = CNT_ZERO;
                end else if (cnt_q == CNT_LAST) begin
                    cnt_d = CNT_ZERO;
                    state_d = SCS_ST_CAPTURE;
                end else begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
            SCS_ST_CAPTURE: begin
                state_d = SCS_ST_RUN;
            end
            SCS_ST_RUN: begin
                if (busy) begin
                    cnt_d = CNT_ZERO;
                    state_d = SCS_ST_SAMPLE;
                end
            end
            default: begin
                cnt_d = CNT_ZERO;
                state_d = SCS_ST_SAMPLE;
            end
        endcase
    end

    // reset release always starts a fresh sampling window
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_q <= SCS_ST_SAMPLE;
            cnt_q <= CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    scs_strap_hold #(
        .W(SCS_NPIN),
        .RST_VAL(SCS_STRAP_DEFAULT)
    ) u_hold (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .load_i(load),
        .d_i(strap_in_i),
        .q_o(strap_q)
    );

    // pin drivers: off unless the next state is run
    logic [SCS_NPIN-1:0] pin_d;
    logic [SCS_NPIN-1:0] pin_q;
    logic [SCS_NPIN-1:0] oe_d;
    logic [SCS_NPIN-1:0] oe_q;
    logic valid_d;
    logic valid_q;

    always_comb begin
        pin_d = func_i.out;
        oe_d = '0;
        valid_d = 1'b0;
        if (state_d == SCS_ST_RUN) begin
            oe_d = func_i.oe;
            valid_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_q <= '0;
            oe_q <= '0;
            valid_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
            oe_q <= oe_d;
            valid_q <= valid_d;
        end
    end

    assign pin_o = pin_q;
    assign pin_oe_o = oe_q;
    assign cfg_valid_o = valid_q;

    // decode of held straps
    scs_port3_if_e p3_if;
    scs_mgmt_e mgmt;
    logic [1:0] phy_code;
    logic role_hi;
    logic run;
    scs_cfg_s cfg_d;
    scs_cfg_s cfg_q;

    assign p3_if = scs_port3_if_e'({strap_q[SCS_PIN_RXD3],
                                    strap_q[SCS_PIN_RXD2]});
    assign phy_code = {strap_q[SCS_PIN_RXER], strap_q[SCS_PIN_WAKE]};
    assign role_hi = strap_q[SCS_PIN_ROLE];
    assign run = (state_q == SCS_ST_RUN);

    // upper bit set means spi whatever the lower bit says
    always_comb begin
        if (strap_q[SCS_PIN_RXD1]) begin
            mgmt = SCS_MG_SPI;
        end else if (strap_q[SCS_PIN_RXD0]) begin
            mgmt = SCS_MG_I2C;
        end else begin
            mgmt = SCS_MG_MIIM;
        end
    end

    always_comb begin
        cfg_d = '0;
        // forwarding waits for capture as well as the start bit
        cfg_d.forward_en = run &
            (strap_q[SCS_PIN_START] | sw_start_i);
        // inband over i2c is refused in hardware, not just advised
        cfg_d.inband_mgmt_en = ~strap_q[SCS_PIN_INBAND] &
            (mgmt != SCS_MG_I2C);
        cfg_d.port3_if = p3_if;
        cfg_d.mii_phy_mode = (p3_if == SCS_P3_MII) & ~role_hi;
        cfg_d.rmii_ref_out = (p3_if == SCS_P3_RMII) & ~role_hi;
        cfg_d.inband_status_en = (p3_if == SCS_P3_RGMII) &
            role_hi;
        cfg_d.port3_gig = ~strap_q[SCS_PIN_SPEED];
        // flags a board that broke the 100M requirement
        cfg_d.speed_conflict = ~strap_q[SCS_PIN_SPEED] &
            ((p3_if == SCS_P3_MII) | (p3_if == SCS_P3_RMII));
        cfg_d.mgmt = mgmt;
        cfg_d.aneg_eee = (phy_code == SCS_PHY_ANEG);
        cfg_d.force_100fd = (phy_code == SCS_PHY_MDIX) |
            (phy_code == SCS_PHY_MDI);
        cfg_d.fixed_mdix = (phy_code == SCS_PHY_MDIX);
        cfg_d.phy_cfg_rsvd = (phy_code == SCS_PHY_RSVD);
        cfg_d.test_mode = strap_q[SCS_PIN_RXDV];
        cfg_d.emission_filter = strap_q[SCS_PIN_SDO];
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign cfg_o = cfg_q;

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    capture_load_a: assert property (
        state_q == SCS_ST_CAPTURE |=> strap_q == $past(strap_in_i)
    ) else $error("straps not captured from the pins");

    settle_done_a: assert property (
        state_q == SCS_ST_SAMPLE && !busy && cnt_q == CNT_LAST
        |=> state_q == SCS_ST_CAPTURE ##1 state_q == SCS_ST_RUN
    ) else $error("capture did not follow the settle window");

    recapture_a: assert property (
        state_q == SCS_ST_RUN && busy
        |=> state_q == SCS_ST_SAMPLE && cnt_q == CNT_ZERO
    ) else $error("reset or power-down did not reopen sampling");

    hold_stable_a: assert property (
        state_q != SCS_ST_CAPTURE |=> $stable(strap_q)
    ) else $error("held straps changed outside capture");

    pin_release_a: assert property (
        state_q != SCS_ST_RUN |-> pin_oe_o == '0
    ) else $error("strap pin driven while sampling");

    pin_drive_a: assert property (
        state_q == SCS_ST_RUN && $past(state_q) == SCS_ST_RUN
        |-> pin_oe_o == $past(func_i.oe)
    ) else $error("pin enables lost after capture");

    forward_gate_a: assert property (
        1'b1 |=> cfg_o.forward_en ==
            $past(run && (strap_q[SCS_PIN_START] || sw_start_i))
    ) else $error("forwarding enable wrong");

    inband_i2c_a: assert property (
        cfg_o.inband_mgmt_en |-> cfg_o.mgmt != SCS_MG_I2C
    ) else $error("inband management on with i2c");

    refclk_out_a: assert property (
        1'b1 |=> cfg_o.rmii_ref_out ==
            $past(p3_if == SCS_P3_RMII && !role_hi)
    ) else $error("reference clock direction wrong");

    status_en_a: assert property (
        1'b1 |=> cfg_o.inband_status_en ==
            $past(p3_if == SCS_P3_RGMII && role_hi)
    ) else $error("rgmii inband status wrong");

    speed_sel_a: assert property (
        1'b1 |=> cfg_o.port3_gig == !$past(strap_q[SCS_PIN_SPEED])
    ) else $error("port3 speed wrong");

    mgmt_spi_a: assert property (
        1'b1 |=> (cfg_o.mgmt == SCS_MG_SPI) ==
            $past(strap_q[SCS_PIN_RXD1])
    ) else $error("spi select wrong");

    phy_mode_a: assert property (
        cfg_o.force_100fd |-> !cfg_o.aneg_eee && !cfg_o.phy_cfg_rsvd
    ) else $error("phy forced and negotiated at once");

    filter_en_a: assert property (
        1'b1 |=> cfg_o.emission_filter == $past(strap_q[SCS_PIN_SDO])
    ) else $error("emission filter wrong");

    port3_sel_a: assert property (
        1'b1 |=> cfg_o.port3_if ==
            $past({strap_q[SCS_PIN_RXD3], strap_q[SCS_PIN_RXD2]})
    ) else $error("port3 interface select wrong");

    speed_flag_a: assert property (
        1'b1 |=> cfg_o.speed_conflict ==
            $past(!strap_q[SCS_PIN_SPEED] && !strap_q[SCS_PIN_RXD3])
    ) else $error("speed conflict flag wrong");

    test_mode_a: assert property (
        1'b1 |=> cfg_o.test_mode == $past(strap_q[SCS_PIN_RXDV])
    ) else $error("test mode select wrong");

    pin_follow_a: assert property (
        1'b1 |=> pin_o == $past(func_i.out)
    ) else $error("pin data not following function");

endmodule : scs_strap_sampler
`default_nettype wire

// ===== bench/scs_board_model.sv
// board strap resistors and pin wire resolution
`timescale 1ns/100ps
`default_nettype none
module scs_board_model
    import scs_pkg::*;
(
    input wire logic [SCS_NPIN-1:0] strap_val_i,
    input wire logic [SCS_NPIN-1:0] pin_i,
    input wire logic [SCS_NPIN-1:0] pin_oe_i,
    output logic [SCS_NPIN-1:0] wire_o
);
    // released pins settle to the resistor level, driven ones follow us
    always_comb begin
        for (int b = 0; b < SCS_NPIN; b++) begin
            wire_o[b] = pin_oe_i[b] ? pin_i[b] : strap_val_i[b];
        end
    end
endmodule : scs_board_model
`default_nettype wire

// ===== bench/scs_strap_sampler_tb.sv
// self-checking bench for the strap sampler
`timescale 1ns/100ps
`default_nettype none
module scs_strap_sampler_tb
    import scs_pkg::*;
;
    localparam int N = 2;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sw_reset_i = 1'b0;
    logic pwr_down_i = 1'b0;
    logic sw_start_i = 1'b0;
    logic [SCS_NPIN-1:0] strap_val = SCS_STRAP_DEFAULT;
    logic [SCS_NPIN-1:0] strap_in;
    scs_pin_s func = '{out: 12'ha5a, oe: 12'hfff};
    logic [SCS_NPIN-1:0] pin_o;
    logic [SCS_NPIN-1:0] pin_oe_o;
    logic cfg_valid_o;
    scs_cfg_s cfg_o;
    int miscompares = 0;
    int samples_checked = 0;
    logic [11:0] tbl [6] = '{12'h2a9, 12'hbd5, 12'h1eb,
                             12'h019, 12'h11f, 12'h09f};

    scs_strap_sampler #(.SETTLE_CYC(N)) dut (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .sw_reset_i(sw_reset_i),
        .pwr_down_i(pwr_down_i), .sw_start_i(sw_start_i),
        .strap_in_i(strap_in), .func_i(func), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .cfg_valid_o(cfg_valid_o), .cfg_o(cfg_o));
    scs_board_model board (.strap_val_i(strap_val), .pin_i(pin_o),
        .pin_oe_i(pin_oe_o), .wire_o(strap_in));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic end_sim();
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick

    task automatic chk_vec(input string n, input logic [11:0] e,
                           input logic [11:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk_vec

    task automatic chk_cfg(input scs_cfg_s e, input scs_cfg_s g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("BAD cfg exp %h got %h", e, g);
        end
    endtask : chk_cfg

    // expected decode from the rules alone
    function automatic scs_cfg_s ex(input logic [11:0] s, input logic st);
        scs_cfg_s c;
        logic [1:0] p;
        logic [1:0] h;
        c = '0;
        p = {s[8], s[7]};
        h = {s[9], s[4]};
        c.forward_en = s[0] | st;
        c.mgmt = s[6] ? SCS_MG_SPI : (s[5] ? SCS_MG_I2C : SCS_MG_MIIM);
        c.inband_mgmt_en = !s[1] && c.mgmt != SCS_MG_I2C;
        c.port3_if = scs_port3_if_e'(p);
        c.mii_phy_mode = p == 2'b00 && !s[2];
        c.rmii_ref_out = p == 2'b01 && !s[2];
        c.inband_status_en = p == 2'b11 && s[2];
        c.port3_gig = !s[3];
        c.speed_conflict = !s[3] && !p[1];
        c.aneg_eee = h == 2'b01;
        c.force_100fd = h[1];
        c.fixed_mdix = h == 2'b10;
        c.phy_cfg_rsvd = h == 2'b00;
        c.test_mode = s[10];
        c.emission_filter = s[11];
        return c;
    endfunction : ex

    // how: 0 software reset, 1 power-down, 2 hardware reset
    task automatic cap(input logic [11:0] s, input int how);
        int k;
        strap_val = s;
        if (how == 0) sw_reset_i = 1'b1;
        else if (how == 1) pwr_down_i = 1'b1;
        else rst_n_i = 1'b0;
        tick();
        tick();
        sw_reset_i = 1'b0;
        pwr_down_i = 1'b0;
        rst_n_i = 1'b1;
        k = 0;
        while (cfg_valid_o !== 1'b1 && k < 50) begin
            chk_vec("oe_sampling", 12'h000, pin_oe_o);
            tick();
            k++;
        end
        if (k >= 50) chk_vec("valid", 12'h001, {11'h0, cfg_valid_o});
        tick();
        tick();
    endtask : cap

    task automatic t_defaults();
        cap(SCS_STRAP_DEFAULT, 2);
        chk_cfg(ex(SCS_STRAP_DEFAULT, 1'b0), cfg_o);
        chk_vec("oe_run", func.oe, pin_oe_o);
    endtask : t_defaults

    // every port3, management and phy code, both roles; mii/rmii at 100M
    task automatic t_table();
        for (int i = 0; i < 6; i++) begin
            cap(tbl[i], 0);
            chk_cfg(ex(tbl[i], 1'b0), cfg_o);
            chk_cfg(ex(tbl[i], 1'b0), cfg_o);
        end
    endtask : t_table

    task automatic t_start();
        cap(12'h01e, 0);
        chk_vec("fwd_off", 12'h000, {11'h0, cfg_o.forward_en});
        sw_start_i = 1'b1;
        tick();
        tick();
        chk_vec("fwd_on", 12'h001, {11'h0, cfg_o.forward_en});
        sw_start_i = 1'b0;
    endtask : t_start

    task automatic t_recap();
        cap(12'h09f, 1);
        chk_cfg(ex(12'h09f, 1'b0), cfg_o);
        cap(12'h1eb, 2);
        chk_cfg(ex(12'h1eb, 1'b0), cfg_o);
    endtask : t_recap

    // later pin activity must not reach the held settings
    task automatic t_hold();
        cap(12'hbd5, 0);
        strap_val = 12'h02a;
        func.out = 12'h3c3;
        for (int i = 0; i < 10; i++) tick();
        chk_cfg(ex(12'hbd5, 1'b0), cfg_o);
        chk_vec("pin_out", 12'h3c3, pin_o);
    endtask : t_hold

    initial begin
        #50000;
        miscompares++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        chk_vec("oe_reset", 12'h000, pin_oe_o);
        t_defaults();
        t_table();
        t_start();
        t_recap();
        t_hold();
        end_sim();
    end
endmodule : scs_strap_sampler_tb
`default_nettype wire
